// ===== hdl/eprom_prog_consts.vh
// Purpose: shared offsets, field positions, reset values and timing
// Assumes: 16-bit processor bus address, 8-bit data
// Notes:   included by the programming controller and its array
`ifndef EPROM_PROG_CONSTS_VH
`define EPROM_PROG_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CTRL_ADDR 16'h0007
`define OPTIONS_ADDR 16'h1efe

// ----------------------------------------
// Array regions
// ----------------------------------------
`define MAIN_LO 16'h07ce
`define MAIN_HI 16'h1efd
`define VECT_LO 16'h1ff2
`define VECT_HI 16'h1fff
`define SEC_LO 16'h0100
`define SEC_HI 16'h01ff
`define ARRAY_AW 13
`define ARRAY_BYTES 6206
`define ERASED_BYTE 8'h00

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_FACTORY_BIT 7
`define CTRL_PROTECT_BIT 6
`define CTRL_LATCH_BIT 5
`define CTRL_PULSE_BIT 4
`define CTRL_EXTERNAL_CLOCK_OPTION_BIT 3
`define CTRL_DONE_BIT 0
`define CTRL_RESET 8'h00

// ----------------------------------------
// Options register fields
// ----------------------------------------
`define OPT_PROTECT_BIT 6
`define OPT_WRITE_MASK 8'h5f

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 10000000
`define PROGRAM_TIME_US 5000
`define PROGRAM_CYCLES ((`PROGRAM_TIME_US * (`CLK_HZ / 1000000)))

`endif

// ===== hdl/eprom_array_mem.v
// Purpose: one-time-programmable byte array with registered read data
// Assumes: one read port and one write port on the same clock
// Notes:   a write can only add one bits, as a fused cell would
`include "eprom_prog_consts.vh"

module eprom_array_mem #(
   parameter AW = `ARRAY_AW
) (
   input wire ref_clk_i,
   input wire wr_en_i,
   input wire [AW-1:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire [AW-1:0] rd_addr_i,
   output reg [7:0] rd_data_o
);

   reg [7:0] cells [0:(1<<AW)-1];
   integer i;

   // ----------------------------------------
   // Erased state at power-up
   // ----------------------------------------
   initial begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
         cells[i] = `ERASED_BYTE;
      end
      rd_data_o = `ERASED_BYTE;
   end

   always @(posedge ref_clk_i) begin
      // [RL13] Bits only set
      if (wr_en_i) begin
         cells[wr_addr_i] <= cells[wr_addr_i] | wr_data_i;
      end
      rd_data_o <= cells[rd_addr_i];
   end

endmodule

// ===== hdl/eprom_program_control.v
// Purpose: programming control for the on-chip one-time-programmable array
// Assumes: one 10 MHz clock; stop_i and boot_mode_i from same-clock logic
// Notes:   supply sense pin is synchronised before use
//
// Behaviour
// [RL1] Latch enable without pulse: array writes capture address and up to four bytes.
// [RL2] Latch enable clear: array reads normally and code may run from it.
// [RL3] Power-on, external reset and STOP clear latch enable.
// [RL4] Pulse bit sets only with latch enable already set and a byte latched.
// [RL5] Software cannot clear the pulse; clearing latch enable clears it.
// [RL6] Reset loads protect copy from the options protect bit.
// [RL7] Protect copy stays readable while latch enable is set.
// [RL8] Control bit 7 always reads zero.
// [RL9] No fetches from the array while latch enable is set.
// [RL10] Unprogrammed bytes read as all zeros.
// [RL11] Batched bytes share all address bits but the lowest two.
// [RL12] 6206-byte array; 256-byte secondary array ignores protection.
// [RL13] Reprogramming a byte can only add one bits.
// [RL14] Outside switch raises supply only after the pulse bit is set.
// [RL15] Control at 0007: protect copy 6, latch 5, pulse 4, ext clock 3.
// [RL16] Protect copy mirrors options register at 1EFE, kept over reset.
// [RL17] Vectors occupy array top, 1FF2 through 1FFF.
// [RL18] Protect set: main array refuses changes; reads unaffected.
// [RL19] Options register writable only in bootstrap loader mode.
// [RL20] Writes outside the first latched group leave the batch unchanged.
`include "eprom_prog_consts.vh"

module eprom_program_control #(
   parameter PROGRAM_CYCLES = `PROGRAM_CYCLES,
   parameter CNT_W = 16
) (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire [15:0] addr_i,
   input wire [7:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   input wire fetch_i,
   output wire [7:0] rd_data_o,
   input wire stop_i,
   input wire boot_mode_i,
   input wire supply_sense_i,
   output wire program_pulse_o,
   output wire programming_supply_pin_o,
   output wire array_readable_o,
   output wire fetch_refused_o,
   output wire external_clock_option_o,
   output wire [7:0] nonvolatile_options_o
);

   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_WAIT = 2'd1;
   localparam [1:0] ST_BURN = 2'd2;
   localparam [1:0] ST_DONE = 2'd3;
   // Count end cut to the counter width on purpose
   localparam [31:0] PGM_LAST_FULL = PROGRAM_CYCLES - 1;
   localparam [CNT_W-1:0] PGM_LAST = PGM_LAST_FULL[CNT_W-1:0];

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg latch_reg, latch_next;
   reg pulse_reg, pulse_next;
   reg protect_copy_reg, protect_copy_next;
   reg external_clock_option_reg, external_clock_option_next;
   reg done_reg, done_next;
   reg load_pending_reg;
   reg [7:0] options_reg;
   reg [10:0] group_reg, group_next;
   reg [3:0] valid_reg, valid_next;
   reg [31:0] bytes_reg, bytes_next;
   reg [1:0] state_reg, state_next;
   reg [CNT_W-1:0] cnt_reg, cnt_next;
   reg [1:0] lane_reg, lane_next;
   reg sense_meta_reg, sense_reg;
   reg [1:0] rd_sel_reg;
   reg fetch_refused_reg;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire hit_ctrl = (addr_i == `CTRL_ADDR);
   wire hit_opt = (addr_i == `OPTIONS_ADDR);
   wire in_main = (addr_i >= `MAIN_LO) && (addr_i <= `MAIN_HI);
   wire in_vect = (addr_i >= `VECT_LO) && (addr_i <= `VECT_HI);
   wire in_sec = (addr_i >= `SEC_LO) && (addr_i <= `SEC_HI);
   // [RL12] Secondary unprotected
   wire in_array = in_main || in_vect || in_sec;
   // [RL17] Vectors protected with main
   // [RL18] Protect blocks main changes
   wire protected_hit = (in_main || in_vect) && options_reg[`OPT_PROTECT_BIT];
   wire [12:0] arr_addr = addr_i[12:0];

   wire mem_wr;
   wire [12:0] mem_wr_addr;
   wire [7:0] mem_rd_data;

   // ----------------------------------------
   // Supply sense synchroniser
   // ----------------------------------------
   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sense_meta_reg <= 1'b0;
         sense_reg <= 1'b0;
      end else begin
         sense_meta_reg <= supply_sense_i;
         sense_reg <= sense_meta_reg;
      end
   end

   // ----------------------------------------
   // Options register, nonvolatile
   // ----------------------------------------
   initial begin
      options_reg = 8'h00;
   end

   always @(posedge ref_clk_i) begin
      // Replaces the byte: the loader sets every option in one write
      // [RL19] Bootstrap-only write
      if (wr_i && hit_opt && boot_mode_i) begin
         options_reg <= wr_data_i & `OPT_WRITE_MASK;
      end
   end

   // ----------------------------------------
   // Control and latch logic
   // ----------------------------------------
   always @* begin
      latch_next = latch_reg;
      pulse_next = pulse_reg;
      protect_copy_next = protect_copy_reg;
      external_clock_option_next = external_clock_option_reg;
      done_next = done_reg;
      group_next = group_reg;
      valid_next = valid_reg;
      bytes_next = bytes_reg;
      state_next = state_reg;
      cnt_next = cnt_reg;
      lane_next = lane_reg;

      // [RL6] Copy at reset release
      if (load_pending_reg) begin
         protect_copy_next = options_reg[`OPT_PROTECT_BIT];
      end

      // [RL16] Track options
      if (!load_pending_reg) begin
         protect_copy_next = options_reg[`OPT_PROTECT_BIT];
      end

      if (wr_i && hit_ctrl) begin
         external_clock_option_next = wr_data_i[`CTRL_EXTERNAL_CLOCK_OPTION_BIT];
         latch_next = wr_data_i[`CTRL_LATCH_BIT];
         // [RL4] Pulse needs latch and a byte
         if (wr_data_i[`CTRL_PULSE_BIT] && latch_reg && (valid_reg != 4'h0)) begin
            pulse_next = 1'b1;
         end
      end

      // [RL1] Capture address and data
      if (wr_i && in_array && latch_reg && !pulse_reg && !protected_hit) begin
         // [RL11] Same group only
         // [RL20] First group kept
         if (valid_reg == 4'h0 || group_reg == arr_addr[12:2]) begin
            group_next = arr_addr[12:2];
            valid_next[arr_addr[1:0]] = 1'b1;
            bytes_next[arr_addr[1:0]*8 +: 8] = wr_data_i;
         end
      end

      // ----------------------------------------
      // Program sequencer
      // ----------------------------------------
      // Count runs only while supply is seen; a slow switch stretches the wait
      // [RL14] Burn only once supply raised
      case (state_reg)
         ST_IDLE: begin
            if (pulse_reg) begin
               state_next = ST_WAIT;
               cnt_next = {CNT_W{1'b0}};
            end
         end
         ST_WAIT: begin
            if (sense_reg) begin
               if (cnt_reg == PGM_LAST) begin
                  state_next = ST_BURN;
                  lane_next = 2'd0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
         end
         ST_BURN: begin
            lane_next = lane_reg + 1'b1;
            if (lane_reg == 2'd3) begin
               state_next = ST_DONE;
               done_next = 1'b1;
            end
         end
         ST_DONE: begin
            state_next = ST_DONE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      // STOP mid-burn drops the batch; unburned lanes stay erased
      // [RL5] Clearing latch clears pulse
      // [RL3] STOP clears latch
      if (!latch_next || stop_i) begin
         latch_next = 1'b0;
         pulse_next = 1'b0;
         valid_next = 4'h0;
         state_next = ST_IDLE;
         if (wr_i && hit_ctrl) begin
            done_next = 1'b0;
         end
      end
   end

   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // [RL3] Reset clears latch
         latch_reg <= 1'b0;
         pulse_reg <= 1'b0;
         protect_copy_reg <= 1'b0;
         external_clock_option_reg <= 1'b0;
         done_reg <= 1'b0;
         load_pending_reg <= 1'b1;
         group_reg <= 11'h000;
         valid_reg <= 4'h0;
         bytes_reg <= 32'h0000_0000;
         state_reg <= ST_IDLE;
         cnt_reg <= {CNT_W{1'b0}};
         lane_reg <= 2'd0;
      end else begin
         latch_reg <= latch_next;
         pulse_reg <= pulse_next;
         protect_copy_reg <= protect_copy_next;
         external_clock_option_reg <= external_clock_option_next;
         done_reg <= done_next;
         load_pending_reg <= 1'b0;
         group_reg <= group_next;
         valid_reg <= valid_next;
         bytes_reg <= bytes_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         lane_reg <= lane_next;
      end
   end

   // ----------------------------------------
   // Array write from latches
   // ----------------------------------------
   // Lanes without a latched byte are skipped rather than written as zero
   assign mem_wr = (state_reg == ST_BURN) && valid_reg[lane_reg];
   assign mem_wr_addr = {group_reg, lane_reg};

   eprom_array_mem #(
      .AW(`ARRAY_AW)
   ) u_array (
      .ref_clk_i(ref_clk_i),
      .wr_en_i(mem_wr),
      .wr_addr_i(mem_wr_addr),
      .wr_data_i(bytes_reg[lane_reg*8 +: 8]),
      .rd_addr_i(arr_addr),
      .rd_data_o(mem_rd_data)
   );

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   localparam [1:0] SEL_NONE = 2'd0;
   localparam [1:0] SEL_CTRL = 2'd1;
   localparam [1:0] SEL_OPT = 2'd2;
   localparam [1:0] SEL_ARRAY = 2'd3;

   always @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_sel_reg <= SEL_NONE;
         fetch_refused_reg <= 1'b0;
      end else begin
         rd_sel_reg <= SEL_NONE;
         fetch_refused_reg <= 1'b0;
         if (rd_i) begin
            if (hit_ctrl) begin
               rd_sel_reg <= SEL_CTRL;
            end else if (hit_opt) begin
               rd_sel_reg <= SEL_OPT;
            // [RL2] Normal reads when latch clear
            end else if (in_array && !latch_reg) begin
               rd_sel_reg <= SEL_ARRAY;
            end
            // Data still reads zero; the flag lets the core trap the fetch
            // [RL9] Fetch refused under latch
            if (fetch_i && in_array && latch_reg) begin
               fetch_refused_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Control view and read mux
   // ----------------------------------------
   reg [7:0] ctrl_view;
   reg [7:0] rd_mux;

   always @* begin
      ctrl_view = `CTRL_RESET;
      // [RL8] Factory bit reads zero
      ctrl_view[`CTRL_FACTORY_BIT] = 1'b0;
      // [RL15] Control layout
      // [RL7] Protect copy always visible
      ctrl_view[`CTRL_PROTECT_BIT] = protect_copy_reg;
      ctrl_view[`CTRL_LATCH_BIT] = latch_reg;
      ctrl_view[`CTRL_PULSE_BIT] = pulse_reg;
      ctrl_view[`CTRL_EXTERNAL_CLOCK_OPTION_BIT] = external_clock_option_reg;
      ctrl_view[`CTRL_DONE_BIT] = done_reg;
      case (rd_sel_reg)
         SEL_CTRL: rd_mux = ctrl_view;
         SEL_OPT: rd_mux = options_reg;
         // [RL10] Erased cells hold zero
         SEL_ARRAY: rd_mux = mem_rd_data;
         default: rd_mux = `ERASED_BYTE;
      endcase
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Pin follows the pulse bit; the switch outside adds its own delay
   assign rd_data_o = rd_mux;
   assign program_pulse_o = pulse_reg;
   assign programming_supply_pin_o = pulse_reg;
   assign array_readable_o = ~latch_reg;
   assign fetch_refused_o = fetch_refused_reg;
   assign external_clock_option_o = external_clock_option_reg;
   assign nonvolatile_options_o = options_reg;

endmodule

// ===== verif/eprom_program_control_assertions.sv
// Purpose: temporal checks on the programming controller ports
// Assumes: one clock, reset asynchronous and active low
// Notes:   bound to every controller instance
`include "eprom_prog_consts.vh"
module eprom_program_control_assertions (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire [15:0] addr_i,
   input wire [7:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   input wire fetch_i,
   input wire [7:0] rd_data_o,
   input wire stop_i,
   input wire boot_mode_i,
   input wire program_pulse_o,
   input wire array_readable_o,
   input wire fetch_refused_o,
   input wire external_clock_option_o,
   input wire [7:0] nonvolatile_options_o
);
   timeunit 1ns;
   timeprecision 1ns;
   wire in_array = (addr_i >= `SEC_LO && addr_i <= `SEC_HI) ||
      (addr_i >= `MAIN_LO && addr_i <= `MAIN_HI) ||
      (addr_i >= `VECT_LO && addr_i <= `VECT_HI);
   wire ctrl_wr = wr_i && addr_i == `CTRL_ADDR;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_locked_fetch;
      rd_i && fetch_i && in_array && !array_readable_o;
   endsequence
   sequence s_latch_req;
      ctrl_wr && wr_data_i[5] && !stop_i;
   endsequence
   a_latch_set: assert property (s_latch_req |=> !array_readable_o)
      else $error("latch enable not set by control write");
   a_stop_clears: assert property (stop_i |=> array_readable_o && !program_pulse_o)
      else $error("stop left latch or pulse set");
   a_pulse_needs_latch: assert property ($rose(program_pulse_o) |->
      !$past(array_readable_o))
      else $error("pulse set without latch");
   a_pulse_with_latch: assert property (program_pulse_o |-> !array_readable_o)
      else $error("pulse outlived latch enable");
   a_pulse_held: assert property (program_pulse_o && !stop_i &&
      !(ctrl_wr && !wr_data_i[5]) |=> program_pulse_o)
      else $error("pulse cleared without latch clear");
   a_locked_fetch: assert property (s_locked_fetch |=>
      fetch_refused_o && rd_data_o == 8'h00)
      else $error("locked fetch not refused");
   a_refusal_cause: assert property (fetch_refused_o |-> $past(rd_i) && $past(fetch_i) &&
      $past(in_array) && !$past(array_readable_o))
      else $error("spurious fetch refusal");
   a_ctrl_read: assert property (rd_i && addr_i == `CTRL_ADDR && !stop_i && $past(nrst_i) |=>
      !rd_data_o[7] && rd_data_o[6] == $past(nonvolatile_options_o[6]) &&
      rd_data_o[5] != $past(array_readable_o))
      else $error("control read value wrong");
   a_opts_gated: assert property (wr_i && addr_i == `OPTIONS_ADDR && !boot_mode_i |=>
      $stable(nonvolatile_options_o))
      else $error("options changed outside loader mode");
   a_clock_option: assert property (ctrl_wr |=>
      external_clock_option_o == $past(wr_data_i[3]))
      else $error("clock option bit not written");
endmodule
bind eprom_program_control eprom_program_control_assertions chk (
   .ref_clk_i(ref_clk_i),
   .nrst_i(nrst_i),
   .addr_i(addr_i),
   .wr_data_i(wr_data_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .fetch_i(fetch_i),
   .rd_data_o(rd_data_o),
   .stop_i(stop_i),
   .boot_mode_i(boot_mode_i),
   .program_pulse_o(program_pulse_o),
   .array_readable_o(array_readable_o),
   .fetch_refused_o(fetch_refused_o),
   .external_clock_option_o(external_clock_option_o),
   .nonvolatile_options_o(nonvolatile_options_o)
);

// ===== verif/supply_switch.sv
// Purpose: outside switch for the programming supply
// Assumes: supply settles a few cycles after the pin rises
// Notes:   supply drops as soon as the pin falls
module supply_switch #(
   parameter DELAY = 3
) (
   input wire ref_clk_i,
   input wire programming_supply_pin_i,
   output logic supply_sense_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial supply_sense_o = 1'b0;
   always @(posedge ref_clk_i) begin
      cnt <= programming_supply_pin_i ? cnt + 1 : 0;
      supply_sense_o <= programming_supply_pin_i && cnt >= DELAY;
   end
endmodule

// ===== verif/tb.sv
// Purpose: self-checking bench for the programming controller
// Assumes: program count shortened to 8 cycles
// Notes:   one task per scenario
`include "eprom_prog_consts.vh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, fetch_i = 0, stop_i = 0;
   logic boot_mode_i = 0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wr_data_i = 8'h00;
   logic [7:0] got;
   wire [7:0] rd_data_o, opts;
   wire pulse, pin, readable, refused, external_clock_option, sense;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   eprom_program_control #(.PROGRAM_CYCLES(8)) DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .fetch_i(fetch_i),
      .rd_data_o(rd_data_o), .stop_i(stop_i), .boot_mode_i(boot_mode_i),
      .supply_sense_i(sense), .program_pulse_o(pulse), .programming_supply_pin_o(pin),
      .array_readable_o(readable), .fetch_refused_o(refused),
      .external_clock_option_o(external_clock_option), .nonvolatile_options_o(opts));
   supply_switch partner (.ref_clk_i(ref_clk_i), .programming_supply_pin_i(pin),
      .supply_sense_o(sense));
   task report_and_stop;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop;
      end
   end
   task do_reset;
      nrst_i <= 0;
      repeat (4) @(posedge ref_clk_i);
      nrst_i <= 1;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 0;
   endtask
   task rd(input logic [15:0] a, input logic f = 0);
      @(posedge ref_clk_i);
      rd_i <= 1;
      fetch_i <= f;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 0;
      fetch_i <= 0;
      #1 got = rd_data_o;
   endtask
   task rd_chk(input string nm, input logic [15:0] a, input logic [7:0] exp);
      rd(a);
      `CHK(nm, exp, got)
   endtask
   // Bounded wait: a refused batch never finishes
   task wait_done;
      got = 8'h00;
      for (int i = 0; i < 40 && got[0] !== 1'b1; i++)
         rd(`CTRL_ADDR);
      wr(`CTRL_ADDR, 8'h00);
   endtask
   task prog(input logic [15:0] a, input logic [7:0] d);
      wr(`CTRL_ADDR, 8'h20);
      wr(a, d);
      wr(`CTRL_ADDR, 8'h30);
      wait_done;
   endtask
   task t_options;
      boot_mode_i <= 1;
      wr(`OPTIONS_ADDR, 8'hbf);
      rd_chk("options", `OPTIONS_ADDR, 8'h1f);
      boot_mode_i <= 0;
      wr(`OPTIONS_ADDR, 8'hff);
      rd_chk("options locked", `OPTIONS_ADDR, 8'h1f);
      `CHK("options out", 8'h1f, opts)
      rd_chk("control", `CTRL_ADDR, 8'h00);
   endtask
   task t_batch;
      wr(`CTRL_ADDR, 8'h20);
      rd_chk("latch", `CTRL_ADDR, 8'h20);
      rd_chk("locked read", 16'h0100, 8'h00);
      wr(`CTRL_ADDR, 8'h30);
      rd_chk("early pulse", `CTRL_ADDR, 8'h20);
      `CHK("pin idle", 1'b0, pin)
      wr(16'h0100, 8'h81);
      wr(16'h0101, 8'h0c);
      wr(16'h0104, 8'hff);
      wr(`CTRL_ADDR, 8'h30);
      rd_chk("pulse", `CTRL_ADDR, 8'h30);
      `CHK("pulse out", 1'b1, pulse)
      `CHK("supply pin", 1'b1, pin)
      wr(`CTRL_ADDR, 8'h20);
      rd_chk("pulse held", `CTRL_ADDR, 8'h30);
      wait_done;
      rd_chk("cleared", `CTRL_ADDR, 8'h00);
      rd_chk("lane 0", 16'h0100, 8'h81);
      rd_chk("lane 1", 16'h0101, 8'h0c);
      rd_chk("other group", 16'h0104, 8'h00);
      rd_chk("blank", 16'h0102, 8'h00);
   endtask
   task t_cumulative;
      prog(16'h0100, 8'h12);
      rd_chk("or write", 16'h0100, 8'h93);
   endtask
   task t_protect;
      boot_mode_i <= 1;
      wr(`OPTIONS_ADDR, 8'h40);
      boot_mode_i <= 0;
      rd_chk("protect copy", `CTRL_ADDR, 8'h40);
      wr(`CTRL_ADDR, 8'h20);
      rd_chk("copy under latch", `CTRL_ADDR, 8'h60);
      wr(`CTRL_ADDR, 8'h00);
      prog(16'h1000, 8'h55);
      rd_chk("protected main", 16'h1000, 8'h00);
      prog(16'h1ff4, 8'h77);
      rd_chk("protected vector", 16'h1ff4, 8'h00);
      prog(16'h0180, 8'h66);
      rd_chk("secondary", 16'h0180, 8'h66);
   endtask
   task t_stop;
      wr(`CTRL_ADDR, 8'h28);
      #1 `CHK("clock option", 1'b1, external_clock_option)
      rd(16'h0180, 1'b1);
      `CHK("refused", 1'b1, refused)
      `CHK("fetch data", 8'h00, got)
      @(posedge ref_clk_i);
      stop_i <= 1;
      @(posedge ref_clk_i);
      stop_i <= 0;
      #1 `CHK("readable", 1'b1, readable)
      rd_chk("after stop", 16'h0180, 8'h66);
   endtask
   task t_reset;
      do_reset;
      rd_chk("reset control", `CTRL_ADDR, 8'h40);
   endtask
   initial begin
      do_reset;
      t_options;
      t_batch;
      t_cumulative;
      t_protect;
      t_stop;
      t_reset;
      report_and_stop;
   end
endmodule
